//--- fmc_pkg.sv
/*
 framer mode control package: register offsets, field layouts, reset
 values, rate codes and timing constants.
 assumes: 20 MHz system clock, 32-bit apb with word-aligned registers.
*/
package fmc_pkg;
    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [11:0] ADDR_MODE = 12'h000;
    localparam logic [11:0] ADDR_FREEZE = 12'h004;
    localparam logic [11:0] ADDR_FEC = 12'h008;
    localparam logic [11:0] ADDR_CEC = 12'h00C;
    localparam logic [11:0] ADDR_CVC = 12'h010;
    localparam logic [11:0] ADDR_EBC = 12'h014;
    localparam logic [11:0] ADDR_RATE = 12'h018;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h01C;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h020;
    // ==========================================================
    // mode register fields
    localparam int MODE_LATCH_BIT = 0;
    localparam int MODE_ALARM_BIT = 1;
    localparam int MODE_LOOP_BIT = 2;
    localparam int MODE_W = 3;
    localparam logic [2:0] MODE_RST = 3'h0;
    // rate register fields: bit0 sel_lo, bit1 sel_hi, bit2 family
    localparam int RATE_W = 3;
    localparam logic [2:0] RATE_RST = 3'h0;
    // interrupt status bits
    localparam int IRQ_SECOND_BIT = 0;
    localparam int IRQ_FREEZE_BIT = 1;
    localparam int IRQ_W = 2;
    localparam logic [1:0] IRQ_RST = 2'h0;
    // counters
    localparam int NUM_CNT = 4;
    localparam int CNT_W = 16;
    localparam logic [3:0] FREEZE_RST = 4'h0;
    // ==========================================================
    // timing
    localparam int CLK_HZ = 20000000;
    localparam int SECOND_S = 1;
    localparam int SECOND_CYC = SECOND_S * CLK_HZ;
    // base highway rate in kbit/s per family (sel bits zero), family 0 then family 1
    localparam int RATE_KBPS_E1 = 2048;
    localparam int RATE_KBPS_T1 = 1544;
    // all-ones alarm pattern bit
    localparam logic ALARM_BIT = 1'b1;
endpackage

//--- fmc_second_tick.sv
/*
 one-second tick divider.
 assumes: free-running i_clk; o_tick pulses one cycle every period.
*/
`timescale 1ns/1ps
module fmc_second_tick #(
    parameter int PERIOD = fmc_pkg::SECOND_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // tick
    output logic o_tick
);
    import fmc_pkg::*;
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } tick_state_type;
    tick_state_type st_ff;
    tick_state_type nxt_st;

    // =========================================================
    // counter
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt == 32'(PERIOD - 1)) begin
            nxt_st.cnt = 32'h0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 32'h1;
        end
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_tick = st_ff.tick;
endmodule

//--- fmc_error_counter.sv
/*
 one error counter with latch and clear; freeze is applied outside by gating i_event.
 assumes: events are single-cycle pulses synchronous to i_clk.
*/
`timescale 1ns/1ps
module fmc_error_counter #(
    parameter int WIDTH = fmc_pkg::CNT_W
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_event,
    input wire logic i_clear,
    input wire logic i_latch,
    input wire logic i_auto,
    // value seen by software
    output logic [WIDTH-1:0] o_value
);
    import fmc_pkg::*;
    typedef struct packed {
        logic [WIDTH-1:0] live;
        logic [WIDTH-1:0] held;
    } cnt_state_type;
    cnt_state_type st_ff;
    cnt_state_type nxt_st;

    // =========================================================
    // counting, saturating at all ones
    always_comb begin
        nxt_st = st_ff;
        if (i_latch) begin
            nxt_st.held = st_ff.live;
            nxt_st.live = i_event ? WIDTH'(1) : '0;
        end else if (i_clear) begin
            nxt_st.live = i_event ? WIDTH'(1) : '0;
        end else if (i_event && st_ff.live != '1) begin
            nxt_st.live = st_ff.live + WIDTH'(1);
        end
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // latched value in auto mode, live value otherwise
    assign o_value = i_auto ? st_ff.held : st_ff.live;
endmodule

//--- framer_mode_control_fields.sv
/*
 framer mode control: error counter mode, highway rate select, and
 alarm indication insertion, with an apb register slave and interrupt.
 assumes: all data and event inputs synchronous to i_clk; apb master
 keeps the usual two-phase protocol.
*/
//
// Functional notes
// RULE1: latch mode bit picks freeze or auto
// RULE2: host freezes counter before reading it
// RULE3: host reads low byte before high
// RULE4: freeze bit rising edge clears counter
// RULE5: auto mode latches and clears each second
// RULE6: host reads latched value within second
// RULE7: host avoids counters just after tick
// RULE8: three bits select highway data rate
// RULE9: family picks e1 or t1 rate ladder
// RULE10: alarm bit forces alarm on both outputs
// RULE11: local loop returns unaltered transmit data
// RULE12: alarm is continuous all ones
`timescale 1ns/1ps
module framer_mode_control_fields #(
    parameter int SECOND_PERIOD = fmc_pkg::SECOND_CYC,
    parameter int WIDTH = fmc_pkg::CNT_W
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // error events from the receiver
    input wire logic i_framing_error,
    input wire logic i_crc_error,
    input wire logic i_code_violation,
    input wire logic i_e_bit_error,
    // transmit data path
    input wire logic i_tx_data,
    output logic o_line_out_a,
    output logic o_line_out_b,
    output logic o_loop_data,
    // highway rate
    output logic [2:0] o_rate_code,
    output logic [15:0] o_rate_kbps,
    // interrupt
    output logic o_irq
);
    import fmc_pkg::*;

    typedef struct packed {
        logic [MODE_W-1:0] mode;
        logic [NUM_CNT-1:0] freeze;
        logic [RATE_W-1:0] rate;
        logic [IRQ_W-1:0] stat;
        logic [IRQ_W-1:0] mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic line_a;
        logic line_b;
        logic loop_d;
        logic [15:0] kbps;
        logic irq;
    } top_state_type;

    top_state_type st_ff;
    top_state_type nxt_st;

    logic tick;
    logic [NUM_CNT-1:0] evt;
    logic [NUM_CNT-1:0] clr;
    logic [NUM_CNT-1:0][WIDTH-1:0] cnt_val;
    logic wr_en;
    logic rd_en;
    logic [NUM_CNT-1:0] wr_freeze;
    logic auto_mode;

    // =========================================================
    // rate code to kbit/s, used for the o_rate_kbps output only
    function automatic logic [15:0] rate_kbps(input logic [2:0] code);
        logic [15:0] base;
        base = code[2] ? 16'(RATE_KBPS_T1) : 16'(RATE_KBPS_E1);
        rate_kbps = base << code[1:0];
    endfunction

    // address match helper
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] r);
        hit = (a == r);
    endfunction

    // =========================================================
    // one-second tick
    fmc_second_tick #(
        .PERIOD(SECOND_PERIOD)
    ) u_tick (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .o_tick(tick)
    );

    assign evt = {i_e_bit_error, i_code_violation, i_crc_error,
                  i_framing_error};
    assign auto_mode = st_ff.mode[MODE_LATCH_BIT];
    assign wr_en = i_psel && i_penable && i_pwrite && !st_ff.pready;
    assign rd_en = i_psel && i_penable && !i_pwrite && !st_ff.pready;
    assign wr_freeze = i_pwdata[NUM_CNT-1:0];

    // RULE4: clear on freeze rise
    assign clr = (wr_en && hit(i_paddr, ADDR_FREEZE) && !auto_mode) ?
                 (wr_freeze & ~st_ff.freeze) : '0;

    // =========================================================
    // counters, one per error kind
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
            // RULE1: mode selects behaviour
            // RULE5: latch each second
            fmc_error_counter #(
                .WIDTH(WIDTH)
            ) u_cnt (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_event(evt[gi] && !(st_ff.freeze[gi] && !auto_mode)),
                .i_clear(clr[gi]),
                .i_latch(tick && auto_mode),
                .i_auto(auto_mode),
                .o_value(cnt_val[gi])
            );
        end
    endgenerate

    // =========================================================
    // register file, datapath and interrupt next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
        // single wait state: answer in the cycle after access start
        if ((wr_en || rd_en)) begin
            nxt_st.pready = 1'b1;
            nxt_st.prdata = 32'h0;
            case (i_paddr)
                ADDR_MODE: begin
                    nxt_st.prdata = 32'(st_ff.mode);
                    if (wr_en) begin
                        nxt_st.mode = i_pwdata[MODE_W-1:0];
                    end
                end
                ADDR_FREEZE: begin
                    nxt_st.prdata = 32'(st_ff.freeze);
                    if (wr_en) begin
                        nxt_st.freeze = wr_freeze;
                    end
                end
                ADDR_FEC: nxt_st.prdata = 32'(cnt_val[0]);
                ADDR_CEC: nxt_st.prdata = 32'(cnt_val[1]);
                ADDR_CVC: nxt_st.prdata = 32'(cnt_val[2]);
                ADDR_EBC: nxt_st.prdata = 32'(cnt_val[3]);
                ADDR_RATE: begin
                    nxt_st.prdata = 32'(st_ff.rate);
                    if (wr_en) begin
                        nxt_st.rate = i_pwdata[RATE_W-1:0];
                    end
                end
                ADDR_IRQ_STAT: nxt_st.prdata = 32'(st_ff.stat);
                ADDR_IRQ_MASK: begin
                    nxt_st.prdata = 32'(st_ff.mask);
                    if (wr_en) begin
                        nxt_st.mask = i_pwdata[IRQ_W-1:0];
                    end
                end
                default: nxt_st.pslverr = 1'b1;
            endcase
        end
        // write-one-to-clear, then hardware set wins
        if (wr_en && hit(i_paddr, ADDR_IRQ_STAT)) begin
            nxt_st.stat = st_ff.stat & ~i_pwdata[IRQ_W-1:0];
        end
        if (tick && auto_mode) begin
            nxt_st.stat[IRQ_SECOND_BIT] = 1'b1;
        end
        if (|clr) begin
            nxt_st.stat[IRQ_FREEZE_BIT] = 1'b1;
        end
        nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
        // RULE8: rate from three bits
        // RULE9: family ladder select
        nxt_st.kbps = rate_kbps(st_ff.rate);
        // RULE10: alarm on both outputs
        // RULE12: all ones replaces data
        if (st_ff.mode[MODE_ALARM_BIT]) begin
            nxt_st.line_a = ALARM_BIT;
            nxt_st.line_b = ALARM_BIT;
        end else begin
            nxt_st.line_a = i_tx_data;
            nxt_st.line_b = i_tx_data;
        end
        // RULE11: loop keeps raw data
        nxt_st.loop_d = st_ff.mode[MODE_LOOP_BIT] ? i_tx_data : 1'b0;
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '0;
            st_ff.mode <= MODE_RST;
            st_ff.freeze <= FREEZE_RST;
            st_ff.rate <= RATE_RST;
            st_ff.stat <= IRQ_RST;
            st_ff.mask <= IRQ_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =========================================================
    // outputs straight from flops
    assign o_prdata = st_ff.prdata;
    assign o_pready = st_ff.pready;
    assign o_pslverr = st_ff.pslverr;
    assign o_line_out_a = st_ff.line_a;
    assign o_line_out_b = st_ff.line_b;
    assign o_loop_data = st_ff.loop_d;
    assign o_rate_code = st_ff.rate;
    assign o_rate_kbps = st_ff.kbps;
    assign o_irq = st_ff.irq;
endmodule

//--- fmc_checker.sv
/*
 checker for the framer mode control block: apb timing, line outputs,
 loop output and highway rate.
 assumes: bound to framer_mode_control_fields, one clock domain.
*/
`timescale 1ns/1ps
module fmc_checker (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [31:0] o_prdata,
    // data path
    input wire logic i_tx_data,
    input wire logic o_line_out_a,
    input wire logic o_line_out_b,
    input wire logic o_loop_data,
    input wire logic [2:0] o_rate_code,
    input wire logic [15:0] o_rate_kbps
);
    import fmc_pkg::*;
    // ==========================================================
    // mode mirror
    logic [MODE_W-1:0] mode_ff;
    // follows mode writes at the edge the slave takes them
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_ff <= MODE_RST;
        end else if (i_psel && i_penable && i_pwrite && !o_pready
                     && i_paddr == ADDR_MODE) begin
            mode_ff <= i_pwdata[MODE_W-1:0];
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // rate in kbit/s for one code
    function automatic logic [15:0] kbps(input logic [2:0] c);
        kbps = (c[2] ? 16'(RATE_KBPS_T1) : 16'(RATE_KBPS_E1)) << c[1:0];
    endfunction
    pready_wait_a: assert property (i_psel && i_penable && !o_pready
        |=> o_pready) else $error("pready late");
    pready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready too long");
    pready_cause_a: assert property (o_pready
        |-> $past(i_psel && i_penable)) else $error("pready unasked");
    slverr_zero_a: assert property (o_pslverr
        |-> o_pready && o_prdata == 32'h0) else $error("bad slverr");
    line_pair_a: assert property (o_line_out_a == o_line_out_b)
        else $error("line outputs differ");
    alarm_ones_a: assert property (!$past(i_rst) && !o_line_out_a
        |-> !$past(i_tx_data)) else $error("line bit lost");
    loop_copy_a: assert property (!$past(i_rst) && o_loop_data
        |-> $past(i_tx_data)) else $error("loop bit altered");
    rate_kbps_a: assert property (!$past(i_rst)
        |-> o_rate_kbps == kbps($past(o_rate_code)))
        else $error("rate mismatch");
    alarm_force_a: assert property ($past(mode_ff[MODE_ALARM_BIT])
        |-> o_line_out_a) else $error("alarm not sent");
    loop_follow_a: assert property ($past(mode_ff[MODE_LOOP_BIT])
        |-> o_loop_data == $past(i_tx_data)) else $error("loop bit lost");
    line_follow_a: assert property (!$past(i_rst)
        && !$past(mode_ff[MODE_ALARM_BIT])
        |-> o_line_out_a == $past(i_tx_data)) else $error("line bit wrong");
    // main scenarios
    refused_c: cover property (o_pslverr);
    alarm_c: cover property (o_line_out_a [*8]);
    loop_c: cover property (o_loop_data);
endmodule
bind framer_mode_control_fields fmc_checker i_chk (.i_clk(i_clk),
    .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
    .i_tx_data(i_tx_data), .o_line_out_a(o_line_out_a),
    .o_line_out_b(o_line_out_b), .o_loop_data(o_loop_data),
    .o_rate_code(o_rate_code), .o_rate_kbps(o_rate_kbps));

//--- fmc_line_model.sv
/*
 receiver and transmitter side model: error event bursts and a
 changing transmit bit pattern.
 assumes: same clock as the framer; bursts requested by the bench.
*/
`timescale 1ns/1ps
module fmc_line_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // burst request
    input wire logic i_load,
    input wire logic [7:0] i_count,
    // line side
    output logic o_event,
    output logic o_tx_data
);
    // ==========================================================
    // bursts and pattern
    logic [7:0] left_ff;
    logic [3:0] pat_ff;
    // one event a cycle until the burst is spent; pattern never idles
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            left_ff <= 8'h0;
            pat_ff <= 4'h1;
        end else begin
            left_ff <= i_load ? i_count : left_ff - 8'(left_ff != 8'h0);
            pat_ff <= {pat_ff[2:0], pat_ff[3] ^ pat_ff[2]};
        end
    end
    assign o_event = left_ff != 8'h0;
    assign o_tx_data = pat_ff[0];
endmodule

//--- tb.sv
/*
 testbench: apb sequences for rate, freeze, alarm, auto latch, irq.
 assumes: short second period of 100 cycles in the design.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
    bad_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
    import fmc_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ld = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] cnt = 8'h0;
    logic pready, pslverr, la, lb, lp, irq, err, tx, ev, tx_prev;
    logic [2:0] rcode;
    logic [15:0] kbps, exp_kbps;
    int checks = 0, bad_count = 0, cyc = 0;
    // ==========================================================
    // clock, parts and tasks
    always #25 clk = ~clk;
    fmc_line_model i_part (.i_clk(clk), .i_rst(rst), .i_load(ld),
        .i_count(cnt), .o_event(ev), .o_tx_data(tx));
    framer_mode_control_fields #(.SECOND_PERIOD(100)) i_dut (
        .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_framing_error(ev), .i_crc_error(ev), .i_code_violation(ev),
        .i_e_bit_error(ev), .i_tx_data(tx), .o_line_out_a(la),
        .o_line_out_b(lb), .o_loop_data(lp), .o_rate_code(rcode),
        .o_rate_kbps(kbps), .o_irq(irq));
    task final_report;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        `CHK("pready", 1'b1, pready)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        // idle edge: a following call never drives psel twice at once
        @(posedge clk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    task burst(input logic [7:0] n);
        ld <= 1'b1;
        cnt <= n;
        @(posedge clk);
        ld <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        `CHK("irq", 1'b1, irq)
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            final_report;
        end
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdc("mode", ADDR_MODE, 32'h0);
        rdc("mask", ADDR_IRQ_MASK, 32'h0);
        rdc("unmapped", 12'h024, 32'h0);
        `CHK("slverr", 1'b1, err)
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_RATE, 32'(c));
            rdc("rate", ADDR_RATE, 32'(c));
            `CHK("code", 3'(c), rcode)
            exp_kbps = 16'((c > 3 ? RATE_KBPS_T1 : RATE_KBPS_E1) << (c % 4));
            `CHK("kbps", exp_kbps, kbps)
        end
        wr(ADDR_IRQ_MASK, 32'h3);
        burst(8'h5);
        wr(ADDR_FREEZE, 32'hF);
        burst(8'h2);
        for (int k = 0; k < 4; k++)
            rdc("cleared", ADDR_FEC + 12'(4 * k), 32'h0);
        rdc("stat", ADDR_IRQ_STAT, 32'h2);
        `CHK("irq on", 1'b1, irq)
        wr(ADDR_IRQ_STAT, 32'h3);
        repeat (3) @(posedge clk);
        `CHK("irq off", 1'b0, irq)
        wr(ADDR_MODE, 32'h6);
        repeat (2) @(posedge clk);
        tx_prev = tx;
        repeat (8) begin
            @(posedge clk);
            `CHK("line a", 1'b1, la)
            `CHK("line b", 1'b1, lb)
            `CHK("loop", tx_prev, lp)
            tx_prev = tx;
        end
        wr(ADDR_MODE, 32'h1);
        repeat (2) @(posedge clk);
        tx_prev = tx;
        repeat (8) begin
            @(posedge clk);
            `CHK("line free", tx_prev, la)
            `CHK("loop off", 1'b0, lp)
            tx_prev = tx;
        end
        wr(ADDR_FREEZE, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h1);
        wait_irq;
        wr(ADDR_IRQ_STAT, 32'h1);
        repeat (3) @(posedge clk);
        wait_irq;
        burst(8'h3);
        wr(ADDR_IRQ_STAT, 32'h1);
        repeat (3) @(posedge clk);
        wait_irq;
        repeat (21) @(posedge clk);
        for (int k = 0; k < 4; k++)
            rdc("held", ADDR_FEC + 12'(4 * k), 32'h3);
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_IRQ_STAT, 32'h1);
        repeat (110) @(posedge clk);
        `CHK("masked", 1'b0, irq)
        rdc("stat bit", ADDR_IRQ_STAT, 32'h1);
        final_report;
    end
endmodule
